// *** design/mpc_pins.v ***
// Multipurpose pin control: direction, input and output functions
// of four board pins, with the register file that steers them.
// Assumes pin inputs and status flags come from logic on clk;
// pin levels are still passed through a two-stage synchroniser.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "mpc_pins_defines.vh"

module mpc_pins (
	input  wire                     clk,
	input  wire                     rst_n,
	input  wire [`MPC_ADDR_W-1:0]   reg_addr,
	input  wire [`MPC_DATA_W-1:0]   reg_wdata,
	input  wire                     reg_wr,
	input  wire                     reg_rd,
	output reg  [`MPC_DATA_W-1:0]   reg_rdata,
	input  wire [`MPC_NPINS-1:0]    pin_in,
	output reg  [`MPC_NPINS-1:0]    pin_out,
	output reg  [`MPC_NPINS-1:0]    pin_oe_n,
	input  wire                     pll0_loss_of_lock,
	input  wire                     pll1_loss_of_lock,
	input  wire                     pll0_holdover,
	input  wire                     pll1_holdover,
	input  wire                     ref0_loss_of_signal,
	input  wire                     ref1_loss_of_signal,
	output reg  [`MPC_NCLK-1:0]     clock_out_en_by_pin,
	output reg  [`MPC_NCLK-1:0]     clock_out_en_level,
	output reg                      manual_ref_select_pll0_act,
	output reg                      manual_ref_select_pll0,
	output reg                      manual_ref_select_pll1_act,
	output reg                      manual_ref_select_pll1
);

	// ********************************************************
	// Helpers
	// ********************************************************
	// Gathers the 3-bit code of one pin from three bit planes
	function [2:0] fn_code;
		input [3:0] b2;
		input [3:0] b1;
		input [3:0] b0;
		input integer i;
		begin
			fn_code = {b2[i], b1[i], b0[i]};
		end
	endfunction

	// ********************************************************
	// Register file
	// ********************************************************
	reg  [3:0] dir_q;
	reg  [3:0] ifn2_q;
	reg  [3:0] ifn1_q;
	reg  [3:0] ifn0_q;
	reg  [3:0] ofn2_q;
	reg  [3:0] ofn1_q;
	reg  [3:0] ofn0_q;
	reg  [3:0] outval_q;
	reg  [3:0] sync1_q;
	reg  [3:0] sync2_q;
	reg  [3:0] inval;
	reg  [7:0] rdata_d;
	reg  [2:0] ic0;
	reg  [2:0] ic1;
	reg  [2:0] ic2;
	reg  [2:0] ic3;
	reg  [2:0] oc0;
	reg  [2:0] oc1;
	reg  [2:0] oc2;
	reg  [2:0] oc3;
	reg  [3:0] pin_out_d;
	reg  [7:0] en_by_pin_d;
	reg  [7:0] en_level_d;
	reg        ref0_act_d;
	reg        ref1_act_d;

	// Only the low nibble is stored; reserved bits are dropped
	// register reset and write
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_q    <= `MPC_RST_NIB;
			ifn2_q   <= `MPC_RST_NIB;
			ifn1_q   <= `MPC_RST_NIB;
			ifn0_q   <= `MPC_RST_NIB;
			ofn2_q   <= `MPC_RST_NIB;
			ofn1_q   <= `MPC_RST_NIB;
			ofn0_q   <= `MPC_RST_NIB;
			outval_q <= `MPC_RST_NIB;
		end else if (reg_wr) begin
			case (reg_addr)
				`MPC_OFS_DIR:    dir_q    <= reg_wdata[3:0];
				`MPC_OFS_IFN2:   ifn2_q   <= reg_wdata[3:0];
				`MPC_OFS_IFN1:   ifn1_q   <= reg_wdata[3:0];
				`MPC_OFS_IFN0:   ifn0_q   <= reg_wdata[3:0];
				`MPC_OFS_OFN2:   ofn2_q   <= reg_wdata[3:0];
				`MPC_OFS_OFN1:   ofn1_q   <= reg_wdata[3:0];
				`MPC_OFS_OFN0:   ofn0_q   <= reg_wdata[3:0];
				`MPC_OFS_OUTVAL: outval_q <= reg_wdata[3:0];
				default:         dir_q    <= dir_q;
			endcase
		end
	end

	// ********************************************************
	// Pin synchroniser
	// ********************************************************
	// two-stage synchroniser
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= `MPC_RST_NIB;
			sync2_q <= `MPC_RST_NIB;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// ********************************************************
	// Function decode
	// ********************************************************
	always @* begin
		ic0 = fn_code(ifn2_q, ifn1_q, ifn0_q, 0);
		ic1 = fn_code(ifn2_q, ifn1_q, ifn0_q, 1);
		ic2 = fn_code(ifn2_q, ifn1_q, ifn0_q, 2);
		ic3 = fn_code(ifn2_q, ifn1_q, ifn0_q, 3);
		oc0 = fn_code(ofn2_q, ofn1_q, ofn0_q, 0);
		oc1 = fn_code(ofn2_q, ofn1_q, ofn0_q, 1);
		oc2 = fn_code(ofn2_q, ofn1_q, ofn0_q, 2);
		oc3 = fn_code(ofn2_q, ofn1_q, ofn0_q, 3);
	end

	// Input mode functions; reserved codes leave the pin idle
	always @* begin
		en_by_pin_d = `MPC_RST_BYTE;
		ref0_act_d  = 1'b0;
		ref1_act_d  = 1'b0;
		inval = ~dir_q & {(ic3 == `MPC_FN_PLAIN),
			(ic2 == `MPC_FN_PLAIN), (ic1 == `MPC_FN_PLAIN),
			(ic0 == `MPC_FN_PLAIN)} & sync2_q;
		en_by_pin_d[0] = ~dir_q[0] & (ic0 == `MPC_FN_SEL_A);
		en_by_pin_d[4] = ~dir_q[0] & (ic0 == `MPC_FN_SEL_B);
		en_by_pin_d[1] = ~dir_q[1] & (ic1 == `MPC_FN_SEL_A);
		en_by_pin_d[5] = ~dir_q[1] & (ic1 == `MPC_FN_SEL_B);
		en_by_pin_d[2] = ~dir_q[2] & (ic2 == `MPC_FN_SEL_A);
		en_by_pin_d[6] = ~dir_q[2] & (ic2 == `MPC_FN_SEL_B);
		ref0_act_d = ~dir_q[2] & (ic2 == `MPC_FN_REFSEL);
		en_by_pin_d[3] = ~dir_q[3] & (ic3 == `MPC_FN_SEL_A);
		en_by_pin_d[7] = ~dir_q[3] & (ic3 == `MPC_FN_SEL_B);
		ref1_act_d = ~dir_q[3] & (ic3 == `MPC_FN_REFSEL);
		en_level_d = en_by_pin_d & {sync2_q, sync2_q};
	end

	// Output mode functions; reserved codes drive low
	always @* begin
		pin_out_d = `MPC_RST_NIB;
		case (oc0)
			`MPC_FN_PLAIN: pin_out_d[0] = outval_q[0];
			`MPC_FN_SEL_A: pin_out_d[0] = pll0_loss_of_lock;
			`MPC_FN_SEL_B: pin_out_d[0] = pll1_loss_of_lock;
			default:       pin_out_d[0] = 1'b0;
		endcase
		case (oc1)
			`MPC_FN_PLAIN: pin_out_d[1] = outval_q[1];
			`MPC_FN_SEL_A: pin_out_d[1] = pll0_holdover;
			`MPC_FN_SEL_B: pin_out_d[1] = pll1_holdover;
			default:       pin_out_d[1] = 1'b0;
		endcase
		case (oc2)
			`MPC_FN_PLAIN: pin_out_d[2] = outval_q[2];
			`MPC_FN_SEL_A: pin_out_d[2] = ref0_loss_of_signal;
			`MPC_FN_SEL_B: pin_out_d[2] = ref1_loss_of_signal;
			default:       pin_out_d[2] = 1'b0;
		endcase
		case (oc3)
			`MPC_FN_PLAIN: pin_out_d[3] = outval_q[3];
			`MPC_FN_SEL_A: pin_out_d[3] = pll1_loss_of_lock;
			`MPC_FN_SEL_B: pin_out_d[3] = ref1_loss_of_signal;
			default:       pin_out_d[3] = 1'b0;
		endcase
		pin_out_d = pin_out_d & dir_q;
	end

	// ********************************************************
	// Read mux
	// ********************************************************
	// Reserved bits and unmapped addresses read zero
	always @* begin
		rdata_d = `MPC_RST_BYTE;
		case (reg_addr)
			`MPC_OFS_DIR:    rdata_d[3:0] = dir_q;
			`MPC_OFS_IFN2:   rdata_d[3:0] = ifn2_q;
			`MPC_OFS_IFN1:   rdata_d[3:0] = ifn1_q;
			`MPC_OFS_IFN0:   rdata_d[3:0] = ifn0_q;
			`MPC_OFS_OFN2:   rdata_d[3:0] = ofn2_q;
			`MPC_OFS_OFN1:   rdata_d[3:0] = ofn1_q;
			`MPC_OFS_OFN0:   rdata_d[3:0] = ofn0_q;
			`MPC_OFS_OUTVAL: rdata_d[3:0] = outval_q;
			`MPC_OFS_INVAL:  rdata_d[3:0] = inval;
			default:         rdata_d      = `MPC_RST_BYTE;
		endcase
	end

	// ********************************************************
	// Output flops
	// ********************************************************
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata                  <= `MPC_RST_BYTE;
			pin_out                    <= `MPC_RST_NIB;
			pin_oe_n                   <= 4'hF;
			clock_out_en_by_pin        <= `MPC_RST_BYTE;
			clock_out_en_level         <= `MPC_RST_BYTE;
			manual_ref_select_pll0_act <= 1'b0;
			manual_ref_select_pll0     <= 1'b0;
			manual_ref_select_pll1_act <= 1'b0;
			manual_ref_select_pll1     <= 1'b0;
		end else begin
			// Read data stands in the cycle after each cycle of reg_rd, and is zero otherwise
			reg_rdata <= reg_rd ? rdata_d : `MPC_RST_BYTE;
			pin_out   <= pin_out_d;
			pin_oe_n  <= ~dir_q;
			clock_out_en_by_pin        <= en_by_pin_d;
			clock_out_en_level         <= en_level_d;
			manual_ref_select_pll0_act <= ref0_act_d;
			manual_ref_select_pll0     <= ref0_act_d & sync2_q[2];
			manual_ref_select_pll1_act <= ref1_act_d;
			manual_ref_select_pll1     <= ref1_act_d & sync2_q[3];
		end
	end

endmodule // mpc_pins

// *** include/mpc_pins_defines.vh ***
// Constants for the multipurpose pin control block.
// Assumes an 8-bit register port with a 16-bit byte address.
`ifndef MPC_PINS_DEFINES_VH
`define MPC_PINS_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define MPC_ADDR_W          16
`define MPC_DATA_W          8
`define MPC_OFS_DIR         16'h006E
`define MPC_OFS_IFN2        16'h006F
`define MPC_OFS_IFN1        16'h0070
`define MPC_OFS_IFN0        16'h0071
`define MPC_OFS_OFN2        16'h0072
`define MPC_OFS_OFN1        16'h0073
`define MPC_OFS_OFN0        16'h0074
`define MPC_OFS_RSVD        16'h0075
`define MPC_OFS_OUTVAL      16'h0076
`define MPC_OFS_INVAL       16'h0219

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define MPC_NPINS           4
`define MPC_NCLK            8
`define MPC_FIELD_MSB       3
`define MPC_RST_NIB         4'h0
`define MPC_RST_BYTE        8'h00

// ****************************************************************
// Function codes
// ****************************************************************
`define MPC_FN_PLAIN        3'h0
`define MPC_FN_SEL_A        3'h1
`define MPC_FN_SEL_B        3'h2
`define MPC_FN_REFSEL       3'h5

`endif

// *** tb/mpc_board.sv ***
// Board logic on the four pins.
// Assumes the block drives a pin while its enable is low.
`timescale 1ns/1ps
module mpc_board (
	input  wire [3:0] drv,
	input  wire [3:0] pin_out,
	input  wire [3:0] pin_oe_n,
	output wire [3:0] pin_in
);
	// ************************************************
	// Wire level
	// ************************************************
	// board yields driven pins
	assign pin_in = (pin_oe_n & drv) | (~pin_oe_n & pin_out);
endmodule // mpc_board

// *** tb/mpc_checker.sv ***
// Port checker for the multipurpose pin control block.
// Assumes it is bound into every mpc_pins instance.
`timescale 1ns/1ps
`include "mpc_pins_defines.vh"
module mpc_checker (
	input wire                   clk,
	input wire                   rst_n,
	input wire [`MPC_ADDR_W-1:0] reg_addr,
	input wire [`MPC_DATA_W-1:0] reg_wdata,
	input wire                   reg_wr,
	input wire                   reg_rd,
	input wire [`MPC_DATA_W-1:0] reg_rdata,
	input wire [`MPC_NPINS-1:0]  pin_in,
	input wire [`MPC_NPINS-1:0]  pin_out,
	input wire [`MPC_NPINS-1:0]  pin_oe_n,
	input wire [`MPC_NCLK-1:0]   clock_out_en_by_pin,
	input wire [`MPC_NCLK-1:0]   clock_out_en_level,
	input wire                   manual_ref_select_pll0_act,
	input wire                   manual_ref_select_pll0,
	input wire                   manual_ref_select_pll1_act,
	input wire                   manual_ref_select_pll1
);
	// ************************************************
	// Assertions
	// ************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_dir_drive: assert property (
		reg_wr && reg_addr == `MPC_OFS_DIR
		|-> ##2 pin_oe_n == ~$past(reg_wdata[3:0], 2))
		else $error("driver enable does not follow direction");
	chk_rd_upper: assert property (
		reg_rd |=> reg_rdata[7:4] == 4'h0)
		else $error("upper read bits not zero");
	chk_out_idle: assert property (
		(pin_out & pin_oe_n) == 4'h0)
		else $error("input pin has drive value");
	chk_en_gate: assert property (
		(clock_out_en_level & ~clock_out_en_by_pin) == 8'h00)
		else $error("enable level without pin control");
	chk_en_dir: assert property (
		(clock_out_en_by_pin & ~{pin_oe_n, pin_oe_n}) == 8'h00)
		else $error("output pin controls a clock");
	chk_ref0_gate: assert property (
		!manual_ref_select_pll0_act |-> !manual_ref_select_pll0)
		else $error("pll0 select level while inactive");
	chk_ref1_gate: assert property (
		!manual_ref_select_pll1_act |-> !manual_ref_select_pll1)
		else $error("pll1 select level while inactive");
	chk_ref_excl: assert property (
		manual_ref_select_pll0_act |-> pin_oe_n[2]
		&& !clock_out_en_by_pin[2] && !clock_out_en_by_pin[6])
		else $error("pin 2 has two functions");
	chk_en_sync: assert property (
		clock_out_en_by_pin[0] [*4]
		|-> clock_out_en_level[0] == $past(pin_in[0], 3))
		else $error("enable level latency wrong");
	chk_ref_sync: assert property (
		manual_ref_select_pll1_act [*4]
		|-> manual_ref_select_pll1 == $past(pin_in[3], 3))
		else $error("pll1 select latency wrong");
endmodule // mpc_checker
bind mpc_pins mpc_checker i_chk (.*);

// *** tb/testbench.sv ***
// Self-checking bench for the multipurpose pin control block.
// Assumes the board model and the bound checker.
`timescale 1ns/1ps
module testbench;
	// ************************************************
	// Signals and instances
	// ************************************************
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [15:0] a_r = 16'h0000;
	reg  [7:0]  d_r = 8'h00;
	reg         wr_r = 1'b0;
	reg         rd_r = 1'b0;
	reg  [3:0]  drv = 4'h0;
	reg  [5:0]  st = 6'h00;
	reg  [2:0]  k;
	wire [7:0]  rdata;
	wire [3:0]  p_in;
	wire [3:0]  p_out;
	wire [3:0]  oe_n;
	wire [7:0]  en_by;
	wire [7:0]  en_lv;
	wire        a0, s0, a1, s1;
	integer     err_total = 0;
	integer     checked = 0;
	integer     cyc = 0;
	integer     i, j;
	always #2.5 clk = ~clk;
	mpc_board i_board (.drv(drv), .pin_out(p_out), .pin_oe_n(oe_n),
		.pin_in(p_in));
	mpc_pins i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(a_r),
		.reg_wdata(d_r), .reg_wr(wr_r), .reg_rd(rd_r), .reg_rdata(rdata),
		.pin_in(p_in), .pin_out(p_out), .pin_oe_n(oe_n),
		.pll0_loss_of_lock(st[0]), .pll1_loss_of_lock(st[1]),
		.pll0_holdover(st[2]), .pll1_holdover(st[3]),
		.ref0_loss_of_signal(st[4]), .ref1_loss_of_signal(st[5]),
		.clock_out_en_by_pin(en_by), .clock_out_en_level(en_lv),
		.manual_ref_select_pll0_act(a0), .manual_ref_select_pll0(s0),
		.manual_ref_select_pll1_act(a1), .manual_ref_select_pll1(s1));
	// ************************************************
	// Tasks
	// ************************************************
	task chk(input [7:0] got, input [7:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [15:0] a, input [7:0] d);
		begin
			@(posedge clk);
			wr_r <= 1'b1;
			a_r <= a;
			d_r <= d;
			@(posedge clk);
			wr_r <= 1'b0;
		end
	endtask
	task rd(input [15:0] a, input [7:0] e);
		begin
			@(posedge clk);
			rd_r <= 1'b1;
			a_r <= a;
			@(posedge clk);
			rd_r <= 1'b0;
			#1;
			chk(rdata, e);
		end
	endtask
	task settle;
		begin
			repeat (4) @(posedge clk);
			#1;
		end
	endtask
	function [3:0] ex(input [2:0] c, input [5:0] s);
		ex = c == 3'h1 ? {s[1], s[4], s[2], s[0]} :
			c == 3'h2 ? {s[5], s[5], s[3], s[1]} : 4'h0;
	endfunction
	task t_regs;
		begin
			chk({4'h0, oe_n}, 8'h0F);
			for (i = 16'h6E; i < 16'h77; i = i + 1)
				rd(i[15:0], 8'h00);
			for (i = 16'h6E; i < 16'h77; i = i + 1)
				if (i != 16'h75) begin
					wr(i[15:0], 8'h0F);
					rd(i[15:0], 8'h0F);
					wr(i[15:0], 8'h00);
				end
			wr(16'h0100, 8'h0F);
			rd(16'h0100, 8'h00);
			wr(16'h0219, 8'h0F);
			rd(16'h0219, 8'h00);
		end
	endtask
	task t_gpi;
		begin
			drv <= 4'h5;
			settle;
			rd(16'h0219, 8'h05);
			wr(16'h0071, 8'h01);
			settle;
			rd(16'h0219, 8'h04);
			chk(en_lv, 8'h01);
		end
	endtask
	task t_clken;
		begin
			for (j = 0; j < 2; j = j + 1) begin
				wr(16'h0070, j ? 8'h0F : 8'h00);
				wr(16'h0071, j ? 8'h00 : 8'h0F);
				drv <= 4'hA;
				settle;
				chk(en_by, j ? 8'hF0 : 8'h0F);
				chk(en_lv, j ? 8'hA0 : 8'h0A);
			end
		end
	endtask
	task t_refsel;
		begin
			wr(16'h0070, 8'h00);
			wr(16'h006F, 8'h0F);
			wr(16'h0071, 8'h0F);
			drv <= 4'hC;
			settle;
			chk({a0, s0, a1, s1, en_by[3:0]}, 8'hF0);
			rd(16'h0219, 8'h00);
			drv <= 4'h4;
			settle;
			chk({4'h0, a0, s0, a1, s1}, 8'h0E);
			wr(16'h006E, 8'h0F);
			settle;
			chk({4'h0, a0, s0, a1, s1}, 8'h00);
		end
	endtask
	task t_gpo;
		begin
			wr(16'h0076, 8'h05);
			settle;
			chk({oe_n, p_out}, 8'h05);
			for (i = 0; i < 3; i = i + 1) begin
				k = (i == 2) ? 3'h5 : i[2:0] + 3'h1;
				wr(16'h0072, {4'h0, {4{k[2]}}});
				wr(16'h0073, {4'h0, {4{k[1]}}});
				wr(16'h0074, {4'h0, {4{k[0]}}});
				for (j = 0; j < 6; j = j + 1) begin
					st <= 6'h01 << j;
					settle;
					chk(p_out, ex(k, st));
				end
			end
			// Live flag codes on all pins, so gating must hide them
			wr(16'h0072, 8'h00);
			wr(16'h0074, 8'h0F);
			st <= 6'h3F;
			settle;
			chk({oe_n, p_out}, 8'h0F);
			wr(16'h006E, 8'h00);
			settle;
			chk({oe_n, p_out}, 8'hF0);
		end
	endtask
	// ************************************************
	// Run control
	// ************************************************
	task final_report;
		begin
			$display("Checks %0d, errors %0d", checked, err_total);
			if (err_total == 0 && checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			final_report;
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		t_regs;
		t_gpi;
		t_clken;
		t_refsel;
		t_gpo;
		final_report;
	end
endmodule // testbench
